// ==== design/spm_pkg.sv ====
/*
 * Shared constants and types of the byte serial port: register offsets,
 * status bit positions, reset values, rate dividers, control fields and
 * state codes.
 * Assumes a 32-bit APB with byte addresses and one word per register.
 */
package spm_pkg;

   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_DATA = 8'h08;
   localparam logic [7:0] ADDR_PINS = 8'h0c;

   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] PINS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // status bit positions
   localparam int STAT_DONE_BIT = 7;
   localparam int STAT_WCOL_BIT = 6;
   localparam int STAT_DBL_BIT = 0;

   // pin index within the pin control fields
   localparam int PIN_MOSI = 0;
   localparam int PIN_MISO = 1;
   localparam int PIN_SCK = 2;
   localparam int PIN_SS = 3;

   // byte framing
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hf;

   // half sck period in system clocks for rate codes 00..11, normal speed
   localparam int HALF_W = 7;
   localparam logic [HALF_W-1:0] HALF_DIV4 = 7'h02;
   localparam logic [HALF_W-1:0] HALF_DIV16 = 7'h08;
   localparam logic [HALF_W-1:0] HALF_DIV64 = 7'h20;
   localparam logic [HALF_W-1:0] HALF_DIV128 = 7'h40;

   typedef struct packed {
      logic transfer_irq_enable;
      logic port_enable;
      logic bit_order_select;
      logic master_select;
      logic clock_polarity;
      logic clock_phase;
      logic rate_select_high;
      logic rate_select_low;
   } spm_ctrl_s;

   typedef struct packed {
      logic [3:0] out;
      logic [3:0] dir;
   } spm_pins_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_MASTER = 3'b010,
      ST_SLAVE = 3'b100
   } spm_state_e;

   // double speed halves the divider of every rate code
   function automatic logic [HALF_W-1:0] half_period(input logic [1:0] rate,
                                                     input logic dbl);
      logic [HALF_W-1:0] base;
      case (rate)
         2'b00: base = HALF_DIV4;
         2'b01: base = HALF_DIV16;
         2'b10: base = HALF_DIV64;
         default: base = HALF_DIV128;
      endcase
      half_period = dbl ? (base >> 1) : base;
   endfunction : half_period

endpackage : spm_pkg

// ==== design/spm_rate_gen.sv ====
/*
 * Master sck rate generator: one-cycle tick at every half sck period.
 * Assumes run is held high for the whole byte and the rate fields stay
 * unchanged while it runs.
 */
`timescale 1ns/100ps
module spm_rate_gen #(
   parameter int CNT_W = 7
) (
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   // control
   input wire logic run_i,
   input wire logic [1:0] rate_i,
   input wire logic dbl_i,
   // tick
   output logic tick_o
);
   import spm_pkg::*;

   initial begin
      if (CNT_W < HALF_W) begin
         $error("spm_rate_gen: CNT_W too small for the slowest rate");
      end
   end

   logic [CNT_W-1:0] cnt;
   wire logic [CNT_W-1:0] half = CNT_W'(half_period(rate_i, dbl_i));
   wire logic at_end = (cnt == half - CNT_W'(1));

   assign tick_o = run_i & at_end;

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cnt <= '0;
      end else if (CE_I) begin
         if (!run_i || at_end) begin
            cnt <= '0;
         end else begin
            cnt <= cnt + CNT_W'(1);
         end
      end
   end

endmodule : spm_rate_gen

// ==== design/spm_port.sv ====
/*
 * Byte serial port, master or slave, full duplex, behind an APB slave.
 * Assumes pins are joined outside from the _i/_o/_oe triples; sck, mosi,
 * miso and ss arrive asynchronously and are synchronised here.
 *
 */
`timescale 1ns/100ps
module spm_port #(
   parameter int RATE_CNT_W = 7
) (
   // clock, reset, enable
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   input wire logic CE_I,
   // apb slave
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic PWRITE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   output logic [31:0] PRDATA_O,
   output logic PREADY_O,
   output logic PSLVERR_O,
   // events
   input wire logic IRQ_ACK_I,
   output logic IRQ_O,
   output logic WAKE_O,
   // serial pins
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE_O,
   input wire logic MOSI_I,
   output logic MOSI_O,
   output logic MOSI_OE_O,
   input wire logic MISO_I,
   output logic MISO_O,
   output logic MISO_OE_O,
   input wire logic SS_I,
   output logic SS_O,
   output logic SS_OE_O
);
   import spm_pkg::*;

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b,
                                           input logic lsb_first);
      shift_in = lsb_first ? {b, v[7:1]} : {v[6:0], b};
   endfunction : shift_in

   function automatic logic first_bit(input logic [7:0] v, input logic lsb_first);
      first_bit = lsb_first ? v[0] : v[7];
   endfunction : first_bit

   spm_ctrl_s ctrl;
   spm_pins_s pins;
   spm_state_e state;
   spm_state_e next_state;
   logic dbl;
   logic done_flag;
   logic wcol_flag;
   logic clr_armed;
   logic [7:0] shreg;
   logic [7:0] rxbuf;
   logic out_bit;
   logic sck_lvl;
   logic [3:0] edge_cnt;
   logic [2:0] bit_cnt;
   logic [3:0] sync1;
   logic [3:0] sync2;
   logic sck_q;
   logic [7:0] next_shreg;

   // apb decode; registers answer with no wait states
   wire logic setup_rd = PSEL_I & ~PENABLE_I & ~PWRITE_I;
   wire logic access = PSEL_I & PENABLE_I;
   wire logic wr = access & PWRITE_I;
   wire logic rd = access & ~PWRITE_I;
   wire logic hit_ctrl = (PADDR_I == ADDR_CTRL);
   wire logic hit_stat = (PADDR_I == ADDR_STAT);
   wire logic hit_data = (PADDR_I == ADDR_DATA);
   wire logic hit_pins = (PADDR_I == ADDR_PINS);
   wire logic mapped = hit_ctrl | hit_stat | hit_data | hit_pins;
   wire logic [7:0] stat_val = (8'(done_flag) << STAT_DONE_BIT)
                             | (8'(wcol_flag) << STAT_WCOL_BIT)
                             | (8'(dbl) << STAT_DBL_BIT);
   wire logic [7:0] rd_mux = hit_ctrl ? ctrl : hit_stat ? stat_val
                           : hit_data ? rxbuf : hit_pins ? pins : 8'h00;

   assign PREADY_O = 1'b1;
   assign PSLVERR_O = access & ~mapped;

   // synchronised pins, order {ss, sck, miso, mosi}
   wire logic mosi_s = sync2[PIN_MOSI];
   wire logic miso_s = sync2[PIN_MISO];
   wire logic sck_s = sync2[PIN_SCK];
   wire logic ss_s = sync2[PIN_SS];

   wire logic enabled = ctrl.port_enable;
   wire logic is_master = ctrl.master_select;
   wire logic lsb_first = ctrl.bit_order_select;
   wire logic in_master = (state == ST_MASTER);
   wire logic in_slave = (state == ST_SLAVE);
   wire logic mode_fault = enabled & is_master & ~pins.dir[PIN_SS] & ~ss_s;

   // master edges come from the rate generator
   logic tick;
   spm_rate_gen #(
      .CNT_W(RATE_CNT_W)
   ) u_rate (
      .CLOCK_I(CLOCK_I),
      .RESETN_I(RESETN_I),
      .CE_I(CE_I),
      .run_i(in_master),
      .rate_i({ctrl.rate_select_high, ctrl.rate_select_low}),
      .dbl_i(dbl),
      .tick_o(tick)
   );

   // slave edges are seen on the synchronised sck, hence the minimum phase
   wire logic slave_edge = in_slave & (sck_s ^ sck_q);
   wire logic edge_now = (in_master & tick) | slave_edge;
   wire logic lead_now = in_master ? ~edge_cnt[0] : (sck_s != ctrl.clock_polarity);
   wire logic sample_now = edge_now & (lead_now ^ ctrl.clock_phase);
   wire logic setup_now = edge_now & ~sample_now;
   wire logic rx_line = in_master ? miso_s : mosi_s;
   wire logic master_done = in_master & tick & (edge_cnt == LAST_EDGE);
   wire logic slave_done = in_slave & sample_now & (bit_cnt == LAST_BIT);
   wire logic byte_done = master_done | slave_done;
   wire logic busy = in_master | (in_slave & (bit_cnt != 3'h0));
   wire logic data_wr = wr & hit_data;
   wire logic data_load = data_wr & ~busy;
   wire logic collision = data_wr & busy;
   wire logic preload = ~in_master & (bit_cnt == 3'h0) & ~edge_now;
   wire logic data_access = access & hit_data;
   wire logic flag_clr = (clr_armed & data_access) | IRQ_ACK_I;

   always_comb begin
      next_shreg = shreg;
      if (data_load) begin
         next_shreg = PWDATA_I[7:0];
      end else if (sample_now) begin
         next_shreg = shift_in(shreg, rx_line, lsb_first);
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (enabled && is_master && !mode_fault && data_load) begin
               next_state = ST_MASTER;
            end else if (enabled && !is_master && !ss_s) begin
               next_state = ST_SLAVE;
            end
         end
         ST_MASTER: begin
            if (master_done || mode_fault || !enabled) begin
               next_state = ST_IDLE;
            end
         end
         ST_SLAVE: begin
            if (ss_s || !enabled || is_master) begin
               next_state = ST_IDLE;
            end
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sync1 <= 4'h0;
         sync2 <= 4'h0;
         sck_q <= 1'b0;
      end else if (CE_I) begin
         sync1 <= {SS_I, SCK_I, MISO_I, MOSI_I};
         sync2 <= sync1;
         sck_q <= sck_s;
      end
   end

   // register file
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         ctrl <= CTRL_RESET;
         pins <= PINS_RESET;
         dbl <= 1'b0;
         PRDATA_O <= 32'h0000_0000;
      end else if (CE_I) begin
         if (setup_rd) begin
            PRDATA_O <= {24'h00_0000, rd_mux};
         end
         if (wr && hit_ctrl) begin
            ctrl <= PWDATA_I[7:0];
         end
         if (mode_fault) begin
            ctrl.master_select <= 1'b0;
         end
         if (wr && hit_stat) begin
            dbl <= PWDATA_I[STAT_DBL_BIT];
         end
         if (wr && hit_pins) begin
            pins <= PWDATA_I[7:0];
         end
      end
   end

   // flags: a set in the same cycle as a clear wins
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         done_flag <= 1'b0;
         wcol_flag <= 1'b0;
         clr_armed <= 1'b0;
         WAKE_O <= 1'b0;
      end else if (CE_I) begin
         done_flag <= byte_done | mode_fault | (done_flag & ~flag_clr);
         wcol_flag <= collision | (wcol_flag & ~flag_clr);
         if (rd && hit_stat && (done_flag || wcol_flag)) begin
            clr_armed <= 1'b1;
         end else if (data_access) begin
            clr_armed <= 1'b0;
         end
         WAKE_O <= byte_done;
      end
   end

   // shift engine
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= ST_IDLE;
         shreg <= DATA_RESET;
         rxbuf <= DATA_RESET;
         out_bit <= 1'b0;
         sck_lvl <= 1'b0;
         edge_cnt <= 4'h0;
         bit_cnt <= 3'h0;
      end else if (CE_I) begin
         state <= next_state;
         shreg <= next_shreg;
         if (byte_done) begin
            rxbuf <= next_shreg;
         end
         if (preload || setup_now) begin
            out_bit <= first_bit(next_shreg, lsb_first);
         end
         if (in_master && tick) begin
            sck_lvl <= ~sck_lvl;
            edge_cnt <= edge_cnt + 4'h1;
         end else if (!in_master) begin
            sck_lvl <= ctrl.clock_polarity;
            edge_cnt <= 4'h0;
         end
         // leaving the slave state drops any partial byte count
         if (next_state == ST_IDLE) begin
            bit_cnt <= 3'h0;
         end else if (sample_now) begin
            bit_cnt <= bit_cnt + 3'h1;
         end
      end
   end

   assign IRQ_O = done_flag & ctrl.transfer_irq_enable;

   // pin overrides; with the port off the pins are plain software outputs
   wire logic drive_m = enabled & is_master;
   wire logic drive_s = enabled & ~is_master;
   assign MOSI_O = drive_m ? out_bit : pins.out[PIN_MOSI];
   assign SCK_O = drive_m ? sck_lvl : pins.out[PIN_SCK];
   assign MISO_O = drive_s ? out_bit : pins.out[PIN_MISO];
   assign SS_O = pins.out[PIN_SS];
   assign MOSI_OE_O = enabled ? (is_master & pins.dir[PIN_MOSI]) : pins.dir[PIN_MOSI];
   assign SCK_OE_O = enabled ? (is_master & pins.dir[PIN_SCK]) : pins.dir[PIN_SCK];
   assign SS_OE_O = enabled ? (is_master & pins.dir[PIN_SS]) : pins.dir[PIN_SS];
   assign MISO_OE_O = enabled ? (~is_master & pins.dir[PIN_MISO] & ~ss_s)
                              : pins.dir[PIN_MISO];

endmodule : spm_port

// ==== dv/spm_port_monitor.sv ====
/* Checker for the byte serial port, seeing only its top ports.
   Assumes one clock domain; bound to every spm_port instance. */
`timescale 1ns/100ps
module spm_port_monitor
   import spm_pkg::*;
(
   // clock and reset
   input wire logic CLOCK_I,
   input wire logic RESETN_I,
   // apb
   input wire logic PSEL_I,
   input wire logic PENABLE_I,
   input wire logic [7:0] PADDR_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic PREADY_O,
   input wire logic PSLVERR_O,
   // events
   input wire logic IRQ_ACK_I,
   input wire logic IRQ_O,
   input wire logic WAKE_O,
   // pins
   input wire logic SCK_O,
   input wire logic SCK_OE_O,
   input wire logic SS_I,
   input wire logic MISO_OE_O
);
   logic sck_q;
   logic [4:0] tog;
   wire logic mapped = PADDR_I inside {ADDR_CTRL, ADDR_STAT, ADDR_DATA, ADDR_PINS};
   wire logic acc = PSEL_I && PENABLE_I;
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!RESETN_I);
   // driven sck edges since the last byte; cleared on wake, and while sck is not driven so a mode fault cannot carry over
   always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         sck_q <= 1'b0;
         tog <= 5'h00;
      end else begin
         sck_q <= SCK_O;
         if (!SCK_OE_O || WAKE_O) tog <= 5'h00;
         else if (SCK_O != sck_q) tog <= tog + 5'h01;
      end
   end
   AST_PREADY: assert property (PREADY_O) else $error("pready low");
   AST_ERR_ACCESS: assert property (PSLVERR_O |-> acc) else $error("pslverr outside access");
   AST_ERR_ADDR: assert property (acc |-> PSLVERR_O == !mapped) else $error("pslverr wrong");
   AST_RD_HOLD: assert property (!(PSEL_I && !PENABLE_I) |=> $stable(PRDATA_O))
      else $error("read data moved");
   AST_WAKE_PULSE: assert property (WAKE_O |=> !WAKE_O) else $error("wake too long");
   AST_IRQ_ACK: assert property (IRQ_ACK_I && IRQ_O |=> !IRQ_O) else $error("irq kept");
   AST_MISO_RELEASE: assert property (SS_I [*4] |-> !MISO_OE_O)
      else $error("miso driven with select high");
   AST_SCK_MAX: assert property (tog <= 5'h10) else $error("too many sck edges");
   // the last sck edge is still in flight when wake rises, so count it here
   AST_SCK_BYTE: assert property (WAKE_O && SCK_OE_O |-> tog + 5'(SCK_O != sck_q) == 5'h10)
      else $error("byte not 16 sck edges");
endmodule : spm_port_monitor

bind spm_port spm_port_monitor u_mon (.CLOCK_I, .RESETN_I, .PSEL_I, .PENABLE_I, .PADDR_I,
   .PRDATA_O, .PREADY_O, .PSLVERR_O, .IRQ_ACK_I, .IRQ_O, .WAKE_O, .SCK_O, .SCK_OE_O, .SS_I,
   .MISO_OE_O);

// ==== dv/spm_peer.sv ====
/* Peer device on the serial link: mode 0, msb first, with a preset reply byte.
   Assumes the port as master drives sck and mosi and lowers select per byte. */
`timescale 1ns/100ps
module spm_peer (
   // control
   input wire logic en_i,
   input wire logic [7:0] tx_i,
   // serial pins
   input wire logic sck_i,
   input wire logic ss_i,
   input wire logic mosi_i,
   output logic miso_o,
   // result
   output logic [7:0] rx_o
);
   logic [7:0] sh = 8'h00;
   // released line shows the inverse of its last bit, so a stale value cannot pass
   assign miso_o = (en_i && !ss_i) ? sh[7] : ~sh[7];
   always @(negedge ss_i) begin
      sh = tx_i;
      rx_o = 8'h00;
   end
   always @(posedge sck_i) if (en_i && !ss_i) rx_o = {rx_o[6:0], mosi_i};
   always @(negedge sck_i) if (en_i && !ss_i) sh = {sh[6:0], 1'b0};
endmodule : spm_peer

// ==== dv/tb.sv ====
/* Self-checking bench: registers, all master rates, collision, mode fault, slave.
   Assumes spm_port, its bound monitor and the peer model are compiled before it. */
`timescale 1ns/100ps
module tb;
   import spm_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, ack = 1'b0;
   logic tb_sck = 1'b0, tb_mosi = 1'b0, tb_ss = 1'b1, pm_en = 1'b1;
   logic [7:0] paddr = 8'h00, pm_tx = 8'h00, pm_rx;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, irq, pm_miso;
   logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_o, ss_oe;
   wire logic sck_w = sck_oe ? sck_o : tb_sck;
   wire logic mosi_w = mosi_oe ? mosi_o : tb_mosi;
   wire logic miso_w = miso_oe ? miso_o : pm_miso;
   wire logic ss_w = ss_oe ? ss_o : tb_ss;
   int n_fail = 0, check_count = 0, cyc = 0;
   always #2.5 clk = ~clk;
   spm_port #(.RATE_CNT_W(7)) uut (.CLOCK_I(clk), .RESETN_I(rstn), .CE_I(1'b1), .PSEL_I(psel),
      .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
      .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_ACK_I(ack), .IRQ_O(irq), .WAKE_O(),
      .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE_O(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
      .MOSI_OE_O(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE_O(miso_oe),
      .SS_I(ss_w), .SS_O(ss_o), .SS_OE_O(ss_oe));
   spm_peer peer (.en_i(pm_en), .tx_i(pm_tx), .sck_i(sck_w), .ss_i(ss_w), .mosi_i(mosi_w),
      .miso_o(pm_miso), .rx_o(pm_rx));
   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         complete_run();
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge clk);
      pen <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
      apb(1'b0, a, 8'h00, q, e);
   endtask : rd
   task automatic wait_irq(output int n);
      n = 0;
      while (irq !== 1'b1 && n < 2000) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_irq
   task automatic do_ack();
      @(posedge clk);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      @(posedge clk);
      chk(irq, 1'b0, "irq cleared");
   endtask : do_ack
   // sck phases kept well above the slave's sampling limit
   // pol high: idle high, leading falling edge sets up, trailing rising edge samples
   task automatic sbit(input logic m, input logic pol, output logic so);
      @(posedge clk);
      tb_mosi <= m;
      if (pol) tb_sck <= 1'b0;
      repeat (6) @(posedge clk);
      so = miso_w;
      tb_sck <= 1'b1;
      repeat (6) @(posedge clk);
      if (!pol) tb_sck <= 1'b0;
   endtask : sbit
   task automatic sbyte(input logic [7:0] m, input logic pol, output logic [7:0] so);
      for (int k = 7; k >= 0; k--) sbit(m[k], pol, so[k]);
   endtask : sbyte
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int k = 0; k < 8; k++) rev[k] = v[7-k];
   endfunction : rev
   function automatic int half(input logic [1:0] r, input logic d);
      int dv[4] = '{4, 16, 64, 128};
      return d ? dv[r] / 4 : dv[r] / 2;
   endfunction : half
   task automatic mtx(input logic [2:0] i, input logic lsb, input logic [7:0] b, pb);
      logic [31:0] q;
      logic e;
      int h, n;
      h = half(i[1:0], i[2]);
      pm_tx <= pb;
      wr(ADDR_PINS, 8'h0d);
      wr(ADDR_STAT, {7'h00, i[2]});
      wr(ADDR_CTRL, {2'b11, lsb, 3'b100, i[1:0]});
      wr(ADDR_DATA, b);
      if (i == 3'h5) begin
         wr(ADDR_DATA, ~b);
         rd(ADDR_STAT, q, e);
         chk(q[STAT_WCOL_BIT], 1'b1, "wcol");
      end
      wait_irq(n);
      if (i != 3'h5) chk(n >= 16 * h + 1 && n <= 16 * h + 2, 1'b1, "byte time");
      chk(irq, 1'b1, "irq");
      chk(pm_rx, lsb ? rev(b) : b, "mosi byte");
      rd(ADDR_DATA, q, e);
      // miso passes a two-stage synchroniser, too slow for the two fastest rates
      if (h >= 4) chk(q, lsb ? rev(pb) : pb, "rx byte");
      do_ack();
      wr(ADDR_PINS, 8'h8d);
   endtask : mtx
   initial begin
      logic [31:0] q;
      logic e;
      logic [7:0] s, got, mb;
      int n;
      void'($urandom(53));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 4; a++) begin
         rd(8'(a * 4), q, e);
         chk({q, e}, 33'h0, "reset value");
      end
      rd(8'h10, q, e);
      chk({q, e}, 33'h1, "unmapped");
      $display("test registers done");
      for (int i = 0; i < 8; i++) mtx(3'(i), 1'($urandom), 8'($urandom), 8'($urandom));
      $display("test master rates done");
      wr(ADDR_PINS, 8'h05);
      wr(ADDR_CTRL, 8'hd0);
      tb_ss <= 1'b0;
      wait_irq(n);
      chk(irq, 1'b1, "fault done");
      rd(ADDR_CTRL, q, e);
      chk(q[4], 1'b0, "master cleared");
      chk(sck_oe, 1'b0, "sck input");
      do_ack();
      tb_ss <= 1'b1;
      $display("test mode fault done");
      pm_en <= 1'b0;
      wr(ADDR_PINS, 8'h02);
      wr(ADDR_CTRL, 8'hc0);
      for (int k = 0; k < 3; k++) sbit(1'b1, 1'b0, got[k]);
      chk(irq, 1'b0, "idle no shift");
      tb_ss <= 1'b0;
      for (int k = 0; k < 4; k++) sbit(1'b0, 1'b0, got[k]);
      tb_ss <= 1'b1;
      repeat (4) @(posedge clk);
      s = 8'($urandom);
      wr(ADDR_DATA, s);
      tb_ss <= 1'b0;
      sbyte(8'($urandom), 1'b0, got);
      chk(got, s, "slave tx");
      chk(irq, 1'b1, "slave done");
      sbyte(s, 1'b0, got);
      tb_ss <= 1'b1;
      rd(ADDR_DATA, q, e);
      chk(q, {24'h0, s}, "last byte kept");
      $display("test slave done");
      tb_sck <= 1'b1;
      wr(ADDR_CTRL, 8'hcc);
      s = 8'($urandom);
      mb = 8'($urandom);
      wr(ADDR_DATA, s);
      tb_ss <= 1'b0;
      repeat (4) @(posedge clk);
      sbyte(mb, 1'b1, got);
      chk(got, s, "slave tx idle high trailing sample");
      tb_ss <= 1'b1;
      rd(ADDR_DATA, q, e);
      chk(q, {24'h0, mb}, "slave rx idle high trailing sample");
      $display("test slave polarity phase done");
      complete_run();
   end
endmodule : tb
